// [scl_pkg.sv]
// Package for the system control lower-field register bank
package scl_pkg;
  // Register byte offsets
  localparam logic [7:0] SCL_OFS_CTRL0 = 8'h00;
  localparam logic [7:0] SCL_OFS_CTRL1 = 8'h04;
  localparam logic [7:0] SCL_OFS_IRQST = 8'h08;
  localparam logic [7:0] SCL_OFS_IRQMSK = 8'h0C;
  // Field positions
  localparam int SCL_B_ZOOM = 20;
  localparam int SCL_B_BDN = 15;
  localparam int SCL_B_BUP = 14;
  localparam int SCL_B_ACT = 13;
  localparam int SCL_B_ONE = 12;
  localparam int SCL_B_STRM = 11;
  localparam int SCL_B_DUP = 10;
  localparam int SCL_B_DDN = 9;
  localparam int SCL_B_PROBE = 8;
  localparam int SCL_B_LOWP = 6;
  localparam int SCL_B_WP = 5;
  localparam int SCL_B_PAR = 4;
  localparam int SCL_B_KEEP = 1;
  localparam int SCL_B_SEL = 0;
  // Read-write bits of the register and its reset value
  localparam logic [20:0] SCL_RW_MASK = 21'h1FC07B;
  localparam logic [20:0] SCL_RESET = 21'h008060;
  // Interrupt status bits: activity of socket 0 and 1
  localparam logic [1:0] SCL_IRQ_RESET = 2'h0;
endpackage

// [scl_top.sv]
// System control lower fields: register bank with AHB-Lite slave
module scl_top
  import scl_pkg::*;
(
  input  wire logic        core_clk,            // Clock, 10 MHz
  input  wire logic        sys_rst,             // Async reset, high
  input  wire logic        hsel,                // Slave select
  input  wire logic [31:0] haddr,               // Address
  input  wire logic [1:0]  htrans,              // Transfer type
  input  wire logic        hwrite,              // Write
  input  wire logic [2:0]  hsize,               // Size
  input  wire logic [31:0] hwdata,              // Write data
  input  wire logic        hready,              // Bus ready
  output logic      [31:0] hrdata,              // Read data
  output logic             hreadyout,           // Slave ready
  output logic             hresp,               // Response
  input  wire logic [1:0]  cardAccess,          // Access pulse per socket
  input  wire logic [1:0]  probeActive,         // Interrogation running
  input  wire logic        streamActive,        // Power stream shifting
  input  wire logic        upStreamSent,        // Power-up stream done
  input  wire logic        downStreamSent,      // Power-down stream done
  input  wire logic        delayExpired,        // Settling delay over
  input  wire logic        cardParityErr,       // Card parity error
  input  wire logic        powerEvent,          // Power event level
  input  wire logic        ringSignal,          // Ring indicate level
  input  wire logic        ring_out_enable,     // Card control ring enable
  output logic             reduced_zoom_video_en, // Tristate AD25..22
  output logic             read_burst_down_en,  // Downstream bursts
  output logic             read_burst_up_en,    // Upstream bursts
  output logic             low_power_en,        // Power savings
  output logic             identity_write_protect, // Identity read-only
  output logic             hold_clocks_running, // Keep clocks running
  output logic             sysErrReq,           // Parity to system error
  output logic             eventPinOut,         // Shared pin value
  output logic             eventPinOe,          // Shared pin drive enable
  output logic             irqOut               // Interrupt level
);

  // Whole state of the block
  typedef struct packed {
    logic [20:0] ctrl0;      // Function 0 copy
    logic [20:0] ctrl1;      // Function 1 copy
    logic [1:0]  activity;   // Socket activity flags
    logic        stream;     // Stream busy
    logic        power_up_delay_busy;    // Up delay busy
    logic        power_down_delay_busy;  // Down delay busy
    logic [1:0]  probe;      // Probe busy per socket
    logic [1:0]  irqStat;    // Sticky interrupt status
    logic [1:0]  irqMask;    // Interrupt mask
    logic        dphWrite;   // Data phase is a write
    logic        dphRead;    // Data phase is a read
    logic [7:0]  dphAddr;    // Latched offset
    logic [31:0] rdata;      // Read data
    logic        errReq;     // System error request
    logic        pinOut;     // Pin value
    logic        pinOe;      // Pin enable
    logic        irq;        // Interrupt level
  } scl_state_t;

  scl_state_t cur;
  scl_state_t next_st;

  // Builds the read view of one function's copy
  function automatic logic [31:0] scl_view(input logic [20:0] c,
                                           input logic act,
                                           input logic prb,
                                           input logic s, input logic u,
                                           input logic d);
    logic [31:0] v;
    v = {11'h000, c & SCL_RW_MASK};      // reserved R bits zero
    v[SCL_B_ACT] = act;
    v[SCL_B_ONE] = 1'b1;
    v[SCL_B_STRM] = s;
    v[SCL_B_DUP] = u;
    v[SCL_B_DDN] = d;
    v[SCL_B_PROBE] = prb;
    return v;
  endfunction

  logic addrPhase;
  assign addrPhase = hsel & htrans[1] & hready;

  // Next-state logic; a late address is decoded from the latched phase
  always_comb begin
    logic [20:0] wmerge;
    wmerge = 21'h000000;
    next_st = cur;
    next_st.dphWrite = addrPhase & hwrite;
    next_st.dphRead = addrPhase & ~hwrite;
    next_st.dphAddr = addrPhase ? haddr[7:0] : cur.dphAddr;
    next_st.rdata = 32'h00000000;
    // Register writes; reserved RW bits kept as written
    wmerge = hwdata[20:0] & SCL_RW_MASK;
    if (cur.dphWrite) begin
      case (cur.dphAddr)
        SCL_OFS_CTRL0: begin
          next_st.ctrl0 = wmerge;
        end
        SCL_OFS_CTRL1: begin
          // Shared fields act from function 0 only; this copy just stores them
          next_st.ctrl1 = wmerge;
        end
        SCL_OFS_IRQMSK: begin
          next_st.irqMask = hwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    // Reads, with clear-on-read of activity; a new access wins
    if (addrPhase & ~hwrite) begin
      case (haddr[7:0])
        SCL_OFS_CTRL0: begin
          next_st.rdata = scl_view(cur.ctrl0, cur.activity[0],
                                   cur.probe[0], cur.stream,
                                   cur.power_up_delay_busy, cur.power_down_delay_busy);
          next_st.activity[0] = 1'b0;
        end
        SCL_OFS_CTRL1: begin
          next_st.rdata = scl_view(cur.ctrl1, cur.activity[1],
                                   cur.probe[1], cur.stream,
                                   cur.power_up_delay_busy, cur.power_down_delay_busy);
          next_st.activity[1] = 1'b0;
        end
        SCL_OFS_IRQST: begin
          next_st.rdata = {30'h00000000, cur.irqStat};
        end
        SCL_OFS_IRQMSK: begin
          next_st.rdata = {30'h00000000, cur.irqMask};
        end
        default: begin
          next_st.rdata = 32'h00000000;
        end
      endcase
    end
    // Write-one-to-clear status, new events win
    if (cur.dphWrite && cur.dphAddr == SCL_OFS_IRQST) begin
      next_st.irqStat = cur.irqStat & ~hwdata[1:0];
    end
    next_st.activity = next_st.activity | cardAccess;
    next_st.irqStat = next_st.irqStat | cardAccess;
    // Power switch sequencing status
    // A sent pulse wins over an expiry in the same cycle, so a
    // fresh stream is never lost behind the old delay
    if (upStreamSent) begin
      next_st.power_up_delay_busy = 1'b1;
    end else if (delayExpired) begin
      next_st.power_up_delay_busy = 1'b0;
    end
    if (downStreamSent) begin
      next_st.power_down_delay_busy = 1'b1;
    end else if (delayExpired) begin
      next_st.power_down_delay_busy = 1'b0;
    end
    next_st.stream = streamActive | next_st.power_up_delay_busy | next_st.power_down_delay_busy;
    next_st.probe = probeActive;
    // Parity forwarding gated by function 0 copy
    next_st.errReq = cardParityErr & cur.ctrl0[SCL_B_PAR];
    // Shared pin mux
    if (cur.ctrl0[SCL_B_SEL]) begin
      next_st.pinOut = powerEvent;
      next_st.pinOe = 1'b1;
    end else begin
      next_st.pinOut = ringSignal & ring_out_enable;
      next_st.pinOe = ring_out_enable;
    end
    next_st.irq = |(next_st.irqStat & next_st.irqMask);
  end

  // State register; reset to documented defaults
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '0;
      cur.ctrl0 <= SCL_RESET;
      cur.ctrl1 <= SCL_RESET;
      cur.irqStat <= SCL_IRQ_RESET;
    end else begin
      cur <= next_st;
    end
  end

  // Outputs straight from state flops; hreadyout and hresp tied to constants
  assign hrdata = cur.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign reduced_zoom_video_en = cur.ctrl0[SCL_B_ZOOM];
  assign read_burst_down_en = cur.ctrl0[SCL_B_BDN];
  assign read_burst_up_en = cur.ctrl0[SCL_B_BUP];
  assign low_power_en = cur.ctrl0[SCL_B_LOWP];
  assign identity_write_protect = cur.ctrl0[SCL_B_WP];
  assign hold_clocks_running = cur.ctrl0[SCL_B_KEEP];
  assign sysErrReq = cur.errReq;
  assign eventPinOut = cur.pinOut;
  assign eventPinOe = cur.pinOe;
  assign irqOut = cur.irq;

  // Checks next to the logic
  a_parity_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    cardParityErr && !cur.ctrl0[SCL_B_PAR] |=> !sysErrReq)
    else $error("parity error reported while disabled");
  a_parity_pass: assert property (@(posedge core_clk) disable iff (sys_rst)
    cardParityErr && cur.ctrl0[SCL_B_PAR] |=> sysErrReq)
    else $error("parity error not reported");
  a_pin_event: assert property (@(posedge core_clk) disable iff (sys_rst)
    cur.ctrl0[SCL_B_SEL] |=> eventPinOe && eventPinOut == $past(powerEvent))
    else $error("power event not on shared pin");
  a_pin_tristate: assert property (@(posedge core_clk) disable iff (sys_rst)
    !cur.ctrl0[SCL_B_SEL] && !ring_out_enable |=> !eventPinOe)
    else $error("shared pin driven while off");
  a_activity_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    cardAccess[0] |=> cur.activity[0])
    else $error("activity flag not set");
  a_activity_clr: assert property (@(posedge core_clk) disable iff (sys_rst)
    addrPhase && !hwrite && haddr[7:0] == SCL_OFS_CTRL0 && !cardAccess[0]
    |=> !cur.activity[0])
    else $error("activity flag not cleared by read");
  a_read_fixed: assert property (@(posedge core_clk) disable iff (sys_rst)
    addrPhase && !hwrite && haddr[7:0] == SCL_OFS_CTRL1
    |=> hrdata[SCL_B_ONE] && !hrdata[7] && !hrdata[2])
    else $error("reserved read bits wrong");
  a_up_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
    upStreamSent |=> cur.power_up_delay_busy && cur.stream)
    else $error("up delay busy not set");
  a_delay_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    delayExpired && !upStreamSent && !downStreamSent && !streamActive
    |=> !cur.stream && !cur.power_up_delay_busy && !cur.power_down_delay_busy)
    else $error("busy bits not cleared after delay");
  a_probe_track: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> cur.probe == $past(probeActive))
    else $error("probe busy not tracking");

  // Bus decode shared by the checks below
  logic rdCtrl0;
  logic rdCtrl1;
  logic wrCtrl0;
  logic wrCtrl1;
  logic wrStat;
  logic wrMask;
  assign rdCtrl0 = addrPhase & ~hwrite & (haddr[7:0] == SCL_OFS_CTRL0);
  assign rdCtrl1 = addrPhase & ~hwrite & (haddr[7:0] == SCL_OFS_CTRL1);
  assign wrCtrl0 = cur.dphWrite & (cur.dphAddr == SCL_OFS_CTRL0);
  assign wrCtrl1 = cur.dphWrite & (cur.dphAddr == SCL_OFS_CTRL1);
  assign wrStat = cur.dphWrite & (cur.dphAddr == SCL_OFS_IRQST);
  assign wrMask = cur.dphWrite & (cur.dphAddr == SCL_OFS_IRQMSK);

  // Function 0 writes steer the shared controls one cycle later
  a_zoom_write: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrCtrl0
    |=> reduced_zoom_video_en == $past(hwdata[SCL_B_ZOOM]))
    else $error("zoom control not written");
  a_bdn_write: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrCtrl0
    |=> read_burst_down_en == $past(hwdata[SCL_B_BDN]))
    else $error("downstream burst control not written");
  a_bup_write: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrCtrl0
    |=> read_burst_up_en == $past(hwdata[SCL_B_BUP]))
    else $error("upstream burst control not written");
  a_lowp_write: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrCtrl0
    |=> low_power_en == $past(hwdata[SCL_B_LOWP]))
    else $error("low power control not written");
  a_wp_write: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrCtrl0
    |=> identity_write_protect == $past(hwdata[SCL_B_WP]))
    else $error("write protect control not written");
  a_keep_write: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrCtrl0
    |=> hold_clocks_running == $past(hwdata[SCL_B_KEEP]))
    else $error("clock keep control not written");
  a_sel_write: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrCtrl0
    |=> cur.ctrl0[SCL_B_SEL] == $past(hwdata[SCL_B_SEL]))
    else $error("output select not written");
  a_par_write: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrCtrl0
    |=> cur.ctrl0[SCL_B_PAR] == $past(hwdata[SCL_B_PAR]))
    else $error("parity control not written");

  // Function 1 keeps its own copy and never disturbs function 0
  a_func1_isolate: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrCtrl1
    |=> cur.ctrl0 == $past(cur.ctrl0))
    else $error("function 1 write changed function 0");
  a_ctrl1_store: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrCtrl1
    |=> cur.ctrl1[SCL_B_PAR] == $past(hwdata[SCL_B_PAR]) && !cur.ctrl1[13])
    else $error("function 1 copy not stored");

  // Read view: fixed bits, and data only stands after a read
  a_read_one0: assert property (@(posedge core_clk)
    disable iff (sys_rst) rdCtrl0
    |=> hrdata[SCL_B_ONE] && !hrdata[7] && !hrdata[2])
    else $error("function 0 fixed bits wrong");
  a_read_upper: assert property (@(posedge core_clk)
    disable iff (sys_rst) rdCtrl0 || rdCtrl1
    |=> hrdata[31:21] == 11'h000)
    else $error("upper read bits not zero");
  a_hrdata_idle: assert property (@(posedge core_clk)
    disable iff (sys_rst) !(addrPhase && !hwrite)
    |=> hrdata == 32'h00000000)
    else $error("read data outside a read");

  // Power switch busy bits hold until their delay runs out
  a_stream_busy: assert property (@(posedge core_clk)
    disable iff (sys_rst) streamActive
    |=> cur.stream)
    else $error("stream busy not set");
  a_stream_idle: assert property (@(posedge core_clk)
    disable iff (sys_rst) !streamActive && !cur.power_up_delay_busy && !cur.power_down_delay_busy &&
    !upStreamSent && !downStreamSent |=> !cur.stream)
    else $error("stream busy without cause");
  a_down_delay: assert property (@(posedge core_clk)
    disable iff (sys_rst) downStreamSent
    |=> cur.power_down_delay_busy && cur.stream)
    else $error("down delay busy not set");
  a_up_hold: assert property (@(posedge core_clk)
    disable iff (sys_rst) cur.power_up_delay_busy && !delayExpired
    |=> cur.power_up_delay_busy)
    else $error("up delay busy dropped early");
  a_down_hold: assert property (@(posedge core_clk)
    disable iff (sys_rst) cur.power_down_delay_busy && !delayExpired
    |=> cur.power_down_delay_busy)
    else $error("down delay busy dropped early");

  // Activity of socket 1, and a flag holds until it is read
  a_activity_set1: assert property (@(posedge core_clk)
    disable iff (sys_rst) cardAccess[1]
    |=> cur.activity[1])
    else $error("socket 1 activity not set");
  a_activity_clr1: assert property (@(posedge core_clk)
    disable iff (sys_rst) rdCtrl1 && !cardAccess[1]
    |=> !cur.activity[1])
    else $error("socket 1 activity not cleared");
  a_activity_hold: assert property (@(posedge core_clk)
    disable iff (sys_rst) cur.activity[0] && !rdCtrl0
    |=> cur.activity[0])
    else $error("activity flag lost before read");

  // Probe view and the ring path of the shared pin
  a_probe_view: assert property (@(posedge core_clk)
    disable iff (sys_rst) rdCtrl1
    |=> hrdata[SCL_B_PROBE] == $past(cur.probe[1]))
    else $error("probe busy not in read view");
  a_pin_ring: assert property (@(posedge core_clk)
    disable iff (sys_rst) !cur.ctrl0[SCL_B_SEL] && ring_out_enable
    |=> eventPinOe && eventPinOut == $past(ringSignal))
    else $error("ring out not on shared pin");

  // Interrupt level, mask and write-one-to-clear
  a_irq_level: assert property (@(posedge core_clk)
    disable iff (sys_rst) irqOut == |(cur.irqStat & cur.irqMask))
    else $error("interrupt level wrong");
  a_irq_clear: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrStat && hwdata[0] && !cardAccess[0]
    |=> !cur.irqStat[0])
    else $error("status bit not cleared");
  a_mask_write: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrMask
    |=> cur.irqMask == $past(hwdata[1:0]))
    else $error("mask not written");

endmodule

// [scl_far_model.sv]
// Far-side model: card bus and power switch events as one-cycle pulses
module scl_far_model (
  input  wire logic       core_clk,       // Clock
  input  wire logic       sys_rst,        // Async reset, high
  input  wire logic [4:0] pulseReq,       // Held requests from the bench
  output logic      [1:0] cardAccess,     // Access pulse per socket
  output logic            upStreamSent,   // Power-up stream done
  output logic            downStreamSent, // Power-down stream done
  output logic            delayExpired    // Settling delay over
);
  logic [4:0] prevReq;
  logic [4:0] pulses;
  // Edge detect, so a request held long still yields one pulse
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prevReq <= 5'h00;
      pulses  <= 5'h00;
    end else begin
      prevReq <= pulseReq;
      pulses  <= pulseReq & ~prevReq;
    end
  end
  // Pulses fan out one per event line
  assign cardAccess     = pulses[1:0];
  assign upStreamSent   = pulses[2];
  assign downStreamSent = pulses[3];
  assign delayExpired   = pulses[4];
endmodule

// [test_system_control_low_fields.sv]
// Testbench for the system control lower-field register bank
module test_system_control_low_fields;
  import scl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
    logic [5:0]  o;
  } scl_row_t;
  logic        core_clk, sys_rst, hsel, hwrite, hreadyout, hresp, irqOut;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, probeActive, cardAccess;
  logic [2:0]  hsize;
  logic [4:0]  pulseReq;
  logic        streamActive, upStreamSent, downStreamSent, delayExpired;
  logic        cardParityErr, powerEvent, ringSignal, ring_out_enable;
  logic        reduced_zoom_video_en, read_burst_down_en, read_burst_up_en;
  logic        low_power_en, identity_write_protect, hold_clocks_running;
  logic        sysErrReq, eventPinOut, eventPinOe;
  logic [5:0]  outs;
  int          error_cnt, check_count;
  // Writes keep reserved bits 19..16 and 3 at zero
  scl_row_t rows [6] = '{
    '{8'h00, 1'b0, 32'h0, 32'h00009060, 6'h16},
    '{8'h00, 1'b1, 32'h0010FFF7, 32'h0010D073, 6'h3F},
    '{8'h04, 1'b1, 32'h0, 32'h00001000, 6'h3F},
    '{8'h00, 1'b1, 32'h0, 32'h00001000, 6'h00},
    '{8'h10, 1'b1, 32'hFFFFFFFF, 32'h0, 6'h00},
    '{8'h0C, 1'b1, 32'h3, 32'h3, 6'h00}};
  assign outs = {reduced_zoom_video_en, read_burst_down_en, read_burst_up_en,
                 low_power_en, identity_write_protect, hold_clocks_running};
  scl_top uut (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cardAccess,
    .probeActive, .streamActive, .upStreamSent, .downStreamSent,
    .delayExpired, .cardParityErr, .powerEvent, .ringSignal,
    .ring_out_enable, .reduced_zoom_video_en, .read_burst_down_en,
    .read_burst_up_en, .low_power_en, .identity_write_protect,
    .hold_clocks_running, .sysErrReq, .eventPinOut, .eventPinOe, .irqOut);
  scl_far_model far (.core_clk, .sys_rst, .pulseReq, .cardAccess,
    .upStreamSent, .downStreamSent, .delayExpired);
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait for a ready edge; a stuck slave ends the run
  task automatic rdy_edge();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  // One single AHB-Lite word transfer, entered right after an edge
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy_edge();
    htrans <= 2'h0;
    hwdata <= d;
    rdy_edge();
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse(input int b);
    pulseReq[b] <= 1'b1;
    @(posedge core_clk);
    pulseReq[b] <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    sys_rst = 1'b1;
    hsize = 3'h2;
    {hsel, hwrite, htrans, haddr, hwdata, pulseReq, probeActive} = '0;
    {streamActive, cardParityErr, powerEvent, ringSignal} = '0;
    ring_out_enable = 1'b0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    // Table of writes, read-backs and the control levels they set
    for (int i = 0; i < 6; i++) begin
      if (rows[i].w) bus(rows[i].a, 1'b1, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
      chk({26'h0, outs}, {26'h0, rows[i].o});
      chk({31'h0, hresp}, 32'h0);
    end
    // Activity flag, read-clear and the interrupt path
    pulse(0);
    chk({31'h0, irqOut}, 32'h1);
    rdchk(SCL_OFS_IRQST, 32'h1);
    rdchk(SCL_OFS_CTRL0, 32'h00003000);
    rdchk(SCL_OFS_CTRL0, 32'h00001000);
    rdchk(SCL_OFS_CTRL1, 32'h00001000);
    bus(SCL_OFS_IRQMSK, 1'b1, 32'h0);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irqOut}, 32'h0);
    bus(SCL_OFS_IRQST, 1'b1, 32'h1);
    rdchk(SCL_OFS_IRQST, 32'h0);
    // Power stream and settling delays
    streamActive <= 1'b1;
    @(posedge core_clk);
    rdchk(SCL_OFS_CTRL0, 32'h00001800);
    streamActive <= 1'b0;
    pulse(2);
    rdchk(SCL_OFS_CTRL0, 32'h00001C00);
    pulse(4);
    rdchk(SCL_OFS_CTRL0, 32'h00001000);
    pulse(3);
    rdchk(SCL_OFS_CTRL0, 32'h00001A00);
    pulse(4);
    rdchk(SCL_OFS_CTRL0, 32'h00001000);
    probeActive <= 2'h2;
    @(posedge core_clk);
    rdchk(SCL_OFS_CTRL1, 32'h00001100);
    rdchk(SCL_OFS_CTRL0, 32'h00001000);
    // Parity reporting, then the shared event pin
    cardParityErr <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({31'h0, sysErrReq}, 32'h0);
    chk({31'h0, eventPinOe}, 32'h0);
    bus(SCL_OFS_CTRL0, 1'b1, 32'h10);
    ring_out_enable <= 1'b1;
    ringSignal <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({31'h0, sysErrReq}, 32'h1);
    chk({30'h0, eventPinOe, eventPinOut}, 32'h3);
    bus(SCL_OFS_CTRL0, 1'b1, 32'h11);
    powerEvent <= 1'b1;
    ringSignal <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({30'h0, eventPinOe, eventPinOut}, 32'h3);
    // Second reset in mid-run restores defaults
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdchk(SCL_OFS_CTRL0, 32'h00009060);
    chk({26'h0, outs}, 32'h16);
    end_of_test();
  end
endmodule
